// ### pkg/bps_pkg.sv
// Package with constants, states and helper functions for the backplane link.
`default_nettype none
package bps_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int OCTET_W = 8;
    localparam int IRQ_N = 7;
    localparam int IRQ_LVL_W = 3;
    localparam int ID_W = 24;
    localparam int ID_HI_LSB = 16;
    localparam int ID_MID_LSB = 8;
    localparam int ID_LO_LSB = 0;
    localparam logic [7:0] ROM_ID_HI = 8'h27;
    localparam logic [7:0] ROM_ID_MID = 8'h2b;
    localparam logic [7:0] ROM_ID_LO = 8'h2f;
    localparam logic [7:0] ROM_BLANK = 8'h00;
    localparam int CLK_NS = 40;
    localparam int RETRY_WAIT_NS = 2000;
    localparam int RETRY_WAIT_CYC = (RETRY_WAIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAIT_W = 8;

    typedef enum logic [1:0] {SS_IDLE, SS_ACK, SS_RETRY} bps_sst_t;
    typedef enum logic [2:0] {
        MS_IDLE, MS_ADDR, MS_STRB, MS_REL, MS_WAIT
    } bps_mst_t;

    // Lane bit 3 is D31..D24, lane bit 0 is D7..D0.
    function automatic logic [LANES-1:0] bps_lanes(input logic lword_n,
            input logic [1:0] ds_n, input logic a01);
        logic [LANES-1:0] m;
        m = '0;
        if (lword_n) begin
            m[1] = ~ds_n[1];
            m[0] = ~ds_n[0];
        end else if (!a01 && ds_n == 2'b00) begin
            m = 4'hf;
        end else if (!a01 && ds_n == 2'b01) begin
            m = 4'he;
        end else if (a01 && ds_n == 2'b10) begin
            m = 4'h7;
        end
        return m;
    endfunction

    // Byte address carried by a lane for the given word address.
    function automatic logic [7:0] bps_lane_addr(
            input logic [ADDR_W:1] a, input logic lword_n, input int lane);
        logic [1:0] low;
        low = 2'(3 - lane);
        if (lword_n) begin
            return {a, low[0]};
        end
        return {a[ADDR_W:2], low};
    endfunction
endpackage
`default_nettype wire

// ### pkg/bps_if.sv
// Interface carrying the backplane lines between master and slave board.
`default_nettype none
interface bps_if;
    import bps_pkg::*;
    logic sysclk;
    logic as_n;
    logic write_n;
    logic lword_n;
    logic [1:0] ds_n;
    logic [ADDR_W:1] addr;
    logic [DATA_W-1:0] d_mst;
    logic [DATA_W-1:0] d_slv;
    logic [DATA_W-1:0] data;
    logic d_mst_oe;
    logic d_slv_oe;
    logic dtack_oe;
    logic retry_oe;
    logic fail_slv_oe;
    logic fail_mst_oe;
    logic sysreset_oe;
    logic [IRQ_N:1] irq_oe;
    logic dtack_n;
    logic retry_n;
    logic sysfail_n;
    logic sysreset_n;
    logic [IRQ_N:1] irq_n;

    // Open-drain lines are low whenever any party enables its driver.
    assign dtack_n = ~dtack_oe;
    assign retry_n = ~retry_oe;
    assign sysfail_n = ~(fail_slv_oe | fail_mst_oe);
    assign sysreset_n = ~sysreset_oe;
    assign irq_n = ~irq_oe;
    assign data = d_slv_oe ? d_slv : (d_mst_oe ? d_mst : '1);

    modport slave(input as_n, write_n, lword_n, ds_n, addr, data,
        sysfail_n, sysreset_n, output sysclk, d_slv, d_slv_oe, dtack_oe,
        retry_oe, fail_slv_oe, irq_oe);
    modport master(input sysclk, data, dtack_n, retry_n, sysfail_n, irq_n,
        output as_n, write_n, lword_n, ds_n, addr, d_mst, d_mst_oe,
        fail_mst_oe, sysreset_oe);
endinterface
`default_nettype wire

// ### verilog/bps_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`default_nettype none
module bps_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    if (W < 1) begin : g_chk
        $error("bps_sync width must be at least one");
    end

    always_comb begin
        q_next = (s2_reg & s3_reg) | (q_reg & (s2_reg ^ s3_reg));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            q_reg <= RST_VAL;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule
`default_nettype wire

// ### verilog/bps_slave.sv
// Slave board end: byte-lane decode, identifier ROM, retry and utility lines.
`default_nettype none
module bps_slave
    import bps_pkg::*;
#(
    parameter logic [ID_W-1:0] MAKER_ID = 24'h5a3c81 // Arbitrary value.
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    bps_if.slave bus,
    input wire logic busy,
    input wire logic fail_req,
    input wire logic [IRQ_N:1] irq_req,
    output logic wr_valid,
    output logic [DATA_W-1:0] wr_data,
    output logic [LANES-1:0] wr_lanes,
    output logic [ADDR_W:1] wr_addr,
    output logic sysreset_seen,
    output logic sysfail_seen
);
    localparam int LIN_W = 6;
    localparam int USR_W = IRQ_N + 2;
    localparam int BCK_W = 3;

    bps_sst_t state_reg;
    bps_sst_t state_next;
    logic dtack_reg;
    logic dtack_next;
    logic retry_reg;
    logic retry_next;
    logic doe_reg;
    logic doe_next;
    logic [DATA_W-1:0] dout_reg;
    logic [DATA_W-1:0] dout_next;
    logic [DATA_W-1:0] wbuf_reg;
    logic [DATA_W-1:0] wbuf_next;
    logic [LANES-1:0] wlanes_reg;
    logic [LANES-1:0] wlanes_next;
    logic [ADDR_W:1] waddr_reg;
    logic [ADDR_W:1] waddr_next;
    logic wtgl_reg;
    logic wtgl_next;
    logic fail_reg;
    logic fail_next;
    logic [IRQ_N:1] irq_reg;
    logic [IRQ_N:1] irq_next;

    logic [LIN_W-1:0] lin_s;
    logic [USR_W-1:0] usr_s;
    logic [BCK_W-1:0] bck_s;
    logic as_s;
    logic [1:0] ds_s;
    logic wr_s;
    logic rst_n_s;
    logic fail_n_s;
    logic busy_s;
    logic fail_req_s;
    logic [IRQ_N:1] irq_req_s;
    logic strobe;
    logic released;
    logic board_rst;
    logic [LANES-1:0] lanes;

    logic wseen_reg;
    logic wseen_next;
    logic wvalid_reg;
    logic wvalid_next;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] wdata_next;
    logic [LANES-1:0] olanes_reg;
    logic [LANES-1:0] olanes_next;
    logic [ADDR_W:1] oaddr_reg;
    logic [ADDR_W:1] oaddr_next;

    // Identifier octets as read through the configuration ROM space.
    function automatic logic [OCTET_W-1:0] rom_byte(input logic [7:0] a);
        unique case (a)
            ROM_ID_HI: return MAKER_ID[ID_HI_LSB +: OCTET_W];
            ROM_ID_MID: return MAKER_ID[ID_MID_LSB +: OCTET_W];
            ROM_ID_LO: return MAKER_ID[ID_LO_LSB +: OCTET_W];
            default: return ROM_BLANK;
        endcase
    endfunction

    // The link clock doubles as the backplane system clock.
    assign bus.sysclk = link_clk;

    bps_sync #(.W(LIN_W), .RST_VAL(6'h3f)) u_lin_sync (
        .clk(link_clk),
        .rst(sys_rst),
        .d({bus.as_n, bus.ds_n, bus.write_n, bus.sysreset_n,
            bus.sysfail_n}),
        .q(lin_s)
    );

    bps_sync #(.W(USR_W), .RST_VAL('0)) u_usr_sync (
        .clk(link_clk),
        .rst(sys_rst),
        .d({busy, fail_req, irq_req}),
        .q(usr_s)
    );

    bps_sync #(.W(BCK_W), .RST_VAL(3'h6)) u_bck_sync (
        .clk(clk),
        .rst(sys_rst),
        .d({bus.sysreset_n, bus.sysfail_n, wtgl_reg}),
        .q(bck_s)
    );

    assign {as_s, ds_s, wr_s, rst_n_s, fail_n_s} = lin_s;
    assign {busy_s, fail_req_s, irq_req_s} = usr_s;
    assign strobe = !as_s && ds_s != 2'b11;
    assign released = ds_s == 2'b11;
    assign board_rst = !rst_n_s;
    // Byte select is read only while strobes qualify a single-word cycle;
    // multiplexed block phases where the line holds data are not decoded.
    assign lanes = bps_lanes(bus.lword_n, ds_s, bus.addr[1]);

    always_comb begin
        state_next = state_reg;
        dtack_next = dtack_reg;
        retry_next = retry_reg;
        doe_next = doe_reg;
        dout_next = dout_reg;
        wbuf_next = wbuf_reg;
        wlanes_next = wlanes_reg;
        waddr_next = waddr_reg;
        wtgl_next = wtgl_reg;
        fail_next = fail_req_s;
        irq_next = irq_req_s;
        unique case (state_reg)
            SS_IDLE: begin
                if (strobe && busy_s) begin
                    retry_next = 1'b1;
                    state_next = SS_RETRY;
                end else if (strobe && wr_s) begin
                    for (int i = 0; i < LANES; i++) begin
                        if (lanes[i]) begin
                            dout_next[i*OCTET_W +: OCTET_W] = rom_byte(
                                bps_lane_addr(bus.addr, bus.lword_n, i));
                        end else begin
                            dout_next[i*OCTET_W +: OCTET_W] = '0;
                        end
                    end
                    doe_next = 1'b1;
                    dtack_next = 1'b1;
                    state_next = SS_ACK;
                end else if (strobe) begin
                    wbuf_next = bus.data;
                    wlanes_next = lanes;
                    waddr_next = bus.addr;
                    wtgl_next = !wtgl_reg;
                    dtack_next = 1'b1;
                    state_next = SS_ACK;
                end
            end
            SS_ACK: begin
                if (released) begin
                    dtack_next = 1'b0;
                    doe_next = 1'b0;
                    state_next = SS_IDLE;
                end
            end
            SS_RETRY: begin
                if (released) begin
                    retry_next = 1'b0;
                    state_next = SS_IDLE;
                end
            end
        endcase
        if (board_rst) begin
            state_next = SS_IDLE;
            dtack_next = 1'b0;
            retry_next = 1'b0;
            doe_next = 1'b0;
            irq_next = '0;
        end
    end

    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= SS_IDLE;
            dtack_reg <= 1'b0;
            retry_reg <= 1'b0;
            doe_reg <= 1'b0;
            dout_reg <= '0;
            wbuf_reg <= '0;
            wlanes_reg <= '0;
            waddr_reg <= '0;
            wtgl_reg <= 1'b0;
            fail_reg <= 1'b0;
            irq_reg <= '0;
        end else begin
            state_reg <= state_next;
            dtack_reg <= dtack_next;
            retry_reg <= retry_next;
            doe_reg <= doe_next;
            dout_reg <= dout_next;
            wbuf_reg <= wbuf_next;
            wlanes_reg <= wlanes_next;
            waddr_reg <= waddr_next;
            wtgl_reg <= wtgl_next;
            fail_reg <= fail_next;
            irq_reg <= irq_next;
        end
    end

    assign bus.dtack_oe = dtack_reg;
    assign bus.retry_oe = retry_reg;
    assign bus.d_slv_oe = doe_reg;
    assign bus.d_slv = dout_reg;
    assign bus.fail_slv_oe = fail_reg;
    assign bus.irq_oe = irq_reg;

    // The write buffer stays still until the next write, so it is safe to
    // copy once the toggle has crossed.
    always_comb begin
        wseen_next = bck_s[0];
        wvalid_next = bck_s[0] != wseen_reg;
        wdata_next = wdata_reg;
        olanes_next = olanes_reg;
        oaddr_next = oaddr_reg;
        if (wvalid_next) begin
            wdata_next = wbuf_reg;
            olanes_next = wlanes_reg;
            oaddr_next = waddr_reg;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wseen_reg <= 1'b0;
            wvalid_reg <= 1'b0;
            wdata_reg <= '0;
            olanes_reg <= '0;
            oaddr_reg <= '0;
        end else begin
            wseen_reg <= wseen_next;
            wvalid_reg <= wvalid_next;
            wdata_reg <= wdata_next;
            olanes_reg <= olanes_next;
            oaddr_reg <= oaddr_next;
        end
    end

    assign wr_valid = wvalid_reg;
    assign wr_data = wdata_reg;
    assign wr_lanes = olanes_reg;
    assign wr_addr = oaddr_reg;
    assign sysreset_seen = !bck_s[2];
    assign sysfail_seen = !bck_s[1];
endmodule
`default_nettype wire

// ### verilog/bps_master.sv
// Master end: issues single cycles, obeys retry, ranks interrupt requests.
`default_nettype none
module bps_master
    import bps_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    bps_if.master bus,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_wide,
    input wire logic [1:0] req_strb,
    input wire logic [ADDR_W:1] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic rsp_retry,
    input wire logic reset_req,
    input wire logic fail_req,
    output logic [IRQ_LVL_W-1:0] irq_level,
    output logic sysfail_seen
);
    localparam int IN_W = IRQ_N + 3;

    bps_mst_t state_reg;
    bps_mst_t state_next;
    logic as_n_reg;
    logic as_n_next;
    logic [1:0] ds_n_reg;
    logic [1:0] ds_n_next;
    logic write_n_reg;
    logic write_n_next;
    logic lword_n_reg;
    logic lword_n_next;
    logic [1:0] strb_reg;
    logic [1:0] strb_next;
    logic [ADDR_W:1] addr_reg;
    logic [ADDR_W:1] addr_next;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] wdata_next;
    logic doe_reg;
    logic doe_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic rsp_reg;
    logic rsp_next;
    logic retried_reg;
    logic retried_next;
    logic [WAIT_W-1:0] wait_reg;
    logic [WAIT_W-1:0] wait_next;
    logic [IRQ_LVL_W-1:0] lvl_reg;
    logic [IRQ_LVL_W-1:0] lvl_next;
    logic [IN_W-1:0] in_s;
    logic dtack_s;
    logic retry_s;
    logic fail_s;
    logic [IRQ_N:1] irq_s;

    if (RETRY_WAIT_CYC >= 2 ** WAIT_W) begin : g_chk
        $error("retry wait does not fit its counter");
    end

    bps_sync #(.W(IN_W), .RST_VAL('1)) u_in_sync (
        .clk(clk),
        .rst(sys_rst),
        .d({bus.dtack_n, bus.retry_n, bus.sysfail_n, bus.irq_n}),
        .q(in_s)
    );
    assign {dtack_s, retry_s, fail_s, irq_s} = in_s;

    always_comb begin
        state_next = state_reg;
        as_n_next = as_n_reg;
        ds_n_next = ds_n_reg;
        write_n_next = write_n_reg;
        lword_n_next = lword_n_reg;
        strb_next = strb_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        doe_next = doe_reg;
        rdata_next = rdata_reg;
        rsp_next = 1'b0;
        retried_next = 1'b0;
        wait_next = wait_reg;
        lvl_next = '0;
        for (int i = 1; i <= IRQ_N; i++) begin
            if (!irq_s[i]) begin
                lvl_next = IRQ_LVL_W'(i);
            end
        end
        unique case (state_reg)
            MS_IDLE: begin
                if (req_valid) begin
                    write_n_next = !req_write;
                    lword_n_next = !req_wide;
                    strb_next = req_strb;
                    addr_next = req_addr;
                    wdata_next = req_wdata;
                    state_next = MS_ADDR;
                end
            end
            MS_ADDR: begin
                as_n_next = 1'b0;
                ds_n_next = ~strb_reg;
                doe_next = !write_n_reg;
                state_next = MS_STRB;
            end
            MS_STRB: begin
                if (!dtack_s) begin
                    rdata_next = bus.data;
                    rsp_next = 1'b1;
                    as_n_next = 1'b1;
                    ds_n_next = 2'b11;
                    doe_next = 1'b0;
                    state_next = MS_REL;
                end else if (!retry_s) begin
                    retried_next = 1'b1;
                    as_n_next = 1'b1;
                    ds_n_next = 2'b11;
                    doe_next = 1'b0;
                    wait_next = WAIT_W'(RETRY_WAIT_CYC);
                    state_next = MS_WAIT;
                end
            end
            MS_REL: begin
                if (dtack_s && retry_s) begin
                    state_next = MS_IDLE;
                end
            end
            MS_WAIT: begin
                if (wait_reg != '0) begin
                    wait_next = wait_reg - 1'b1;
                end else if (dtack_s && retry_s) begin
                    state_next = MS_ADDR;
                end
            end
            default: state_next = MS_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= MS_IDLE;
            as_n_reg <= 1'b1;
            ds_n_reg <= 2'b11;
            write_n_reg <= 1'b1;
            lword_n_reg <= 1'b1;
            strb_reg <= '0;
            addr_reg <= '0;
            wdata_reg <= '0;
            doe_reg <= 1'b0;
            rdata_reg <= '0;
            rsp_reg <= 1'b0;
            retried_reg <= 1'b0;
            wait_reg <= '0;
            lvl_reg <= '0;
        end else begin
            state_reg <= state_next;
            as_n_reg <= as_n_next;
            ds_n_reg <= ds_n_next;
            write_n_reg <= write_n_next;
            lword_n_reg <= lword_n_next;
            strb_reg <= strb_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            doe_reg <= doe_next;
            rdata_reg <= rdata_next;
            rsp_reg <= rsp_next;
            retried_reg <= retried_next;
            wait_reg <= wait_next;
            lvl_reg <= lvl_next;
        end
    end

    assign bus.as_n = as_n_reg;
    assign bus.ds_n = ds_n_reg;
    assign bus.write_n = write_n_reg;
    assign bus.lword_n = lword_n_reg;
    assign bus.addr = addr_reg;
    assign bus.d_mst = wdata_reg;
    assign bus.d_mst_oe = doe_reg;
    assign bus.fail_mst_oe = fail_req;
    assign bus.sysreset_oe = reset_req;
    assign req_ready = state_reg == MS_IDLE;
    assign rsp_valid = rsp_reg;
    assign rsp_rdata = rdata_reg;
    assign rsp_retry = retried_reg;
    assign irq_level = lvl_reg;
    assign sysfail_seen = !fail_s;
endmodule
`default_nettype wire

// ### verif/bps_link_sva.sv
// Checker for the backplane lines between the master and slave ends.
`default_nettype none
module bps_link_sva
    import bps_pkg::*;
#(
    parameter logic [ID_W-1:0] MAKER_ID = 24'h5a3c81 // Arbitrary value.
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sysclk,
    input wire logic as_n,
    input wire logic write_n,
    input wire logic lword_n,
    input wire logic [1:0] ds_n,
    input wire logic [ADDR_W:1] addr,
    input wire logic [DATA_W-1:0] data,
    input wire logic d_slv_oe,
    input wire logic dtack_oe,
    input wire logic retry_oe,
    input wire logic [IRQ_N:1] irq_oe,
    input wire logic dtack_n,
    input wire logic retry_n,
    input wire logic sysreset_n
);
    timeunit 1ns;
    timeprecision 1ps;
    sequence strobed_s;
        !as_n && ds_n != 2'b11 && sysreset_n;
    endsequence
    sequence idle_s;
        ds_n == 2'b11;
    endsequence
    property rom_p(logic [7:1] a, logic [7:0] v);
        @(posedge sysclk) disable iff (sys_rst)
        $rose(dtack_oe) && write_n && lword_n && ds_n == 2'b10 && addr == a
        |-> data == {24'h000000, v};
    endproperty
    ack_excl_a: assert property (@(posedge sysclk) disable iff (sys_rst)
        !(dtack_oe && retry_oe)) else $error("dtack and retry together");
    ack_cause_a: assert property (@(posedge sysclk) disable iff (sys_rst)
        $rose(dtack_oe) |-> strobed_s) else $error("dtack without strobes");
    ack_bound_a: assert property (@(posedge sysclk) disable iff (sys_rst)
        strobed_s [*7] |-> dtack_oe || retry_oe) else $error("no answer");
    ack_hold_a: assert property (@(posedge sysclk) disable iff (sys_rst)
        (dtack_oe and strobed_s) |=> dtack_oe)
        else $error("dtack dropped early");
    ack_release_a: assert property (@(posedge sysclk) disable iff (sys_rst)
        idle_s [*7] |-> !dtack_oe && !retry_oe && !d_slv_oe)
        else $error("slave lines not released");
    read_drive_a: assert property (@(posedge sysclk) disable iff (sys_rst)
        $rose(dtack_oe) |-> d_slv_oe == write_n) else $error("bad data drive");
    rom_hi_a: assert property (rom_p(7'h13, MAKER_ID[23:16]))
        else $error("high octet wrong");
    rom_mid_a: assert property (rom_p(7'h15, MAKER_ID[15:8]))
        else $error("middle octet wrong");
    rom_lo_a: assert property (rom_p(7'h17, MAKER_ID[7:0]))
        else $error("low octet wrong");
    sysreset_abort_a: assert property (@(posedge sysclk) disable iff (sys_rst)
        (!sysreset_n) [*6] |-> !dtack_oe && !retry_oe && irq_oe == '0)
        else $error("slave active in system reset");
    mst_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !as_n && dtack_n && retry_n |=> !as_n && $stable(addr)
        && $stable(ds_n) && $stable(write_n)) else $error("request not held");
    retry_abandon_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(retry_n) |-> ##[1:8] as_n && ds_n == 2'b11)
        else $error("retry not obeyed");
    done_release_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(dtack_n) |-> ##[1:8] as_n && ds_n == 2'b11)
        else $error("strobes kept after dtack");
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench joining the master and slave ends over the backplane.
`default_nettype none
module tb_top
    import bps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] ID = 24'h3c5a96; // Arbitrary value.
    logic clk, link_clk, sys_rst, busy, m_rst_req, m_fail_req, s_fail_req;
    logic req_valid, req_ready, req_write, req_wide, rsp_valid, rsp_retry;
    logic [1:0] req_strb;
    logic [7:1] req_addr, irq_req, wr_addr;
    logic [31:0] req_wdata, rsp_rdata, wr_data;
    logic wr_valid, s_rst_seen, s_fail_seen, m_fail_seen;
    logic [2:0] irq_level;
    logic [3:0] wr_lanes;
    logic [42:0] wq[$];
    int error_cnt, checked, cycles, retries;
    bps_if i_bps_if();
    bps_master i_bps_master(.clk(clk), .sys_rst(sys_rst), .bus(i_bps_if),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_wide(req_wide), .req_strb(req_strb), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_retry(rsp_retry), .reset_req(m_rst_req), .fail_req(m_fail_req),
        .irq_level(irq_level), .sysfail_seen(m_fail_seen));
    bps_slave #(.MAKER_ID(ID)) i_bps_slave(.clk(clk), .sys_rst(sys_rst),
        .link_clk(link_clk), .bus(i_bps_if), .busy(busy),
        .fail_req(s_fail_req), .irq_req(irq_req), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_lanes(wr_lanes), .wr_addr(wr_addr),
        .sysreset_seen(s_rst_seen), .sysfail_seen(s_fail_seen));
    bps_link_sva #(.MAKER_ID(ID)) sva_u(.clk(clk), .sys_rst(sys_rst),
        .sysclk(i_bps_if.sysclk), .as_n(i_bps_if.as_n),
        .write_n(i_bps_if.write_n), .lword_n(i_bps_if.lword_n),
        .ds_n(i_bps_if.ds_n), .addr(i_bps_if.addr), .data(i_bps_if.data),
        .d_slv_oe(i_bps_if.d_slv_oe), .dtack_oe(i_bps_if.dtack_oe),
        .retry_oe(i_bps_if.retry_oe), .irq_oe(i_bps_if.irq_oe),
        .dtack_n(i_bps_if.dtack_n), .retry_n(i_bps_if.retry_n),
        .sysreset_n(i_bps_if.sysreset_n));
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    initial begin
        link_clk = 0;
        #7;
        forever #80 link_clk = ~link_clk;
    end
    task automatic print_verdict;
        $display("errors %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        if (wr_valid === 1'b1) wq.push_back({wr_lanes, wr_addr, wr_data});
        if (rsp_retry === 1'b1) retries++;
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            print_verdict;
        end
    end
    task automatic chk(input logic [42:0] got, input logic [42:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Returns the lane mask and the read data the slave should give.
    function automatic logic [35:0] model(input logic wide,
            input logic [1:0] s, input logic [7:1] a);
        logic [3:0] m;
        logic [31:0] d;
        logic [7:0] b;
        m = wide ? 4'h0 : {2'b00, s};
        if (wide && !a[1] && s == 2'b11) m = 4'hf;
        if (wide && !a[1] && s == 2'b10) m = 4'he;
        if (wide && a[1] && s == 2'b01) m = 4'h7;
        d = '0;
        for (int l = 0; l < 4; l++) begin
            b = wide ? {a[7:2], 2'(3 - l)} : {a, l == 0};
            if (m[l]) d[8*l +: 8] = b == 8'h27 ? ID[23:16] :
                b == 8'h2b ? ID[15:8] : b == 8'h2f ? ID[7:0] : 8'h00;
        end
        return {m, d};
    endfunction
    task automatic xfer(input logic w, wide, input logic [1:0] s,
            input logic [7:1] a, input logic [31:0] wd,
            output logic [31:0] rd);
        int n;
        for (n = 0; n < 500 && req_ready !== 1'b1; n++) tick(1);
        req_valid = 1;
        req_write = w;
        req_wide = wide;
        req_strb = s;
        req_addr = a;
        req_wdata = wd;
        tick(1);
        req_valid = 0;
        for (n = 0; n < 3000 && rsp_valid !== 1'b1; n++) tick(1);
        rd = rsp_rdata;
        for (n = 0; n < 500 && req_ready !== 1'b1; n++) tick(1);
        tick(8);
    endtask
    task automatic do_rd(input logic wide, input logic [1:0] s,
            input logic [7:1] a);
        logic [31:0] rd;
        logic [35:0] e;
        e = model(wide, s, a);
        xfer(0, wide, s, a, 32'h0, rd);
        chk(43'(rd), 43'(e[31:0]));
    endtask
    task automatic do_wr(input logic wide, input logic [1:0] s,
            input logic [7:1] a, input logic [31:0] wd);
        logic [35:0] e;
        logic [31:0] rd, lm;
        logic [42:0] g;
        e = model(wide, s, a);
        lm = {{8{e[35]}}, {8{e[34]}}, {8{e[33]}}, {8{e[32]}}};
        xfer(1, wide, s, a, wd, rd);
        g = wq.size() != 0 ? wq.pop_front() : 'x;
        chk({g[42:32], g[31:0] & lm}, {e[35:32], a, wd & lm});
    endtask
    initial begin
        logic [7:1] a;
        logic [1:0] s;
        logic [7:0] t;
        logic wide;
        int k;
        {sys_rst, busy, m_rst_req, m_fail_req, s_fail_req} = 5'h10;
        {req_valid, req_write, req_wide, req_strb, req_addr} = '0;
        {req_wdata, irq_req} = '0;
        void'($urandom(32'hddb6));
        repeat (12) @(posedge clk);
        #1 sys_rst = 0;
        tick(6);
        chk(43'({s_rst_seen, s_fail_seen, irq_level}), 43'h0);
        do_rd(0, 2'b01, 7'h13);
        do_rd(0, 2'b01, 7'h15);
        do_rd(0, 2'b01, 7'h17);
        do_rd(1, 2'b11, 7'h12);
        for (int i = 0; i < 16; i++) begin
            do_rd(1'($urandom), 2'($urandom_range(1, 3)),
                7'($urandom_range(16, 23)));
            a = 7'($urandom);
            wide = 1'($urandom);
            k = $urandom_range(0, 2);
            s = wide ? (k == 0 ? 2'b11 : k == 1 ? 2'b10 : 2'b01) :
                2'($urandom_range(1, 3));
            if (wide) a[1] = k == 2;
            do_wr(wide, s, a, $urandom);
        end
        busy = 1;
        fork
            do_wr(1, 2'b11, 7'h40, 32'h1234abcd);
            begin
                tick(150);
                busy = 0;
            end
        join
        chk(43'(retries != 0), 43'h1);
        chk(43'(wq.size()), 43'h0);
        for (int i = 0; i < 8; i++) begin
            t = (8'($urandom) & ((8'h1 << i) - 8'h1)) | (8'h1 << i);
            irq_req = t[7:1];
            tick(40);
            chk(43'(irq_level), 43'(i));
        end
        s_fail_req = 1;
        tick(40);
        chk(43'({m_fail_seen, s_fail_seen}), 43'h3);
        s_fail_req = 0;
        m_fail_req = 1;
        tick(40);
        chk(43'({m_fail_seen, s_fail_seen}), 43'h3);
        m_fail_req = 0;
        tick(40);
        chk(43'({m_fail_seen, s_fail_seen}), 43'h0);
        irq_req = 7'h40;
        m_rst_req = 1;
        tick(40);
        chk(43'({s_rst_seen, irq_level}), 43'h8);
        m_rst_req = 0;
        tick(40);
        chk(43'({s_rst_seen, irq_level}), 43'h7);
        irq_req = 7'h00;
        do_rd(0, 2'b01, 7'h13);
        print_verdict;
    end
endmodule
`default_nettype wire
